// ===== sssp_regs.vh
`ifndef SSSP_REGS_VH
`define SSSP_REGS_VH
// register byte offsets
`define SSSP_TRANSMIT_STATUS_CONTROL_OFF 8'h00
`define SSSP_RECEIVE_STATUS_CONTROL_OFF 8'h04
`define SSSP_TXHOLD_OFF 8'h08
`define SSSP_RXDATA_OFF 8'h0C
`define SSSP_IRQEN_OFF 8'h10
`define SSSP_IRQFLG_OFF 8'h14
`define SSSP_BAUD_OFF 8'h18
`define SSSP_DIVLO_OFF 8'h1C
`define SSSP_DIVHI_OFF 8'h20
`define SSSP_CORE_OFF 8'h24
// transmit_status_control fields
`define SSSP_TX_CLOCK_SOURCE_SELECT 7
`define SSSP_TX_NINE 6
`define SSSP_TX_EN 5
`define SSSP_TX_SYNC 4
`define SSSP_TX_TRMT 1
`define SSSP_TX_NINTH 0
// receive_status_control fields
`define SSSP_RC_PEN 7
`define SSSP_RC_NINE 6
`define SSSP_RC_SINGLE_RECEIVE_ENABLE 5
`define SSSP_RC_CONTINUOUS_RECEIVE_ENABLE 4
`define SSSP_RC_OVERRUN_FLAG 1
`define SSSP_RC_NINTH 0
// irq enable / flag fields
`define SSSP_IRQ_RX 5
`define SSSP_IRQ_TX 4
// core control fields: global, peripheral enables; sleep
`define SSSP_CORE_GIE 7
`define SSSP_CORE_PERIPHERAL_IRQ_EN 6
`define SSSP_CORE_SLEEP 0
// reset values
`define SSSP_TRANSMIT_STATUS_CONTROL_RST 8'h02
`define SSSP_ZERO_RST 8'h00
`define SSSP_IRQFLG_RST 8'h10
// character lengths in shift clocks
`define SSSP_CHAR_BITS 4'h8
`define SSSP_CHAR9_BITS 4'h9
// bus response codes
`define SSSP_RESP_OKAY 2'h0
`define SSSP_RESP_SLVERR 2'h2
`endif

// ===== sssp_sync_slave.v
`timescale 1ns/1ps
// Function
// RQ1: slave mode when sync=1, port enable=1, clock source select=0; clock from pin.
// RQ2: transmitter when both receive enables clear, otherwise receiver.
// RQ3: during sleep first character loads shifter at once, second waits, ready flag clear.
// RQ4: after shift-out, pending moves to shifter and ready flag sets then.
// RQ5: ready flag with peripheral and transmit enables wakes core; global adds service.
// RQ6: ninth transmit bit taken from its field, loaded before the holding write.
// RQ7: transmit enable arms sending; holding register write starts a character.
// RQ8: slave reception behaves as continuous; single receive enable ignored.
// RQ9: continuous receive works during sleep and lands in receive data register.
// RQ10: receive-done with receive enable wakes core; global adds vectoring.
// RQ11: receive-done flag sets on completion; request only when enabled.
// RQ12: ninth receive bit shown for oldest queued character, read before data.
// RQ13: overrun cleared by clearing continuous receive; port disable resets all.
// RQ14: only synchronous slave mode runs during sleep.
// RQ15: both shifters clocked by external shift clock edges.
// RQ16: shift clock pin driver off in slave transmit or receive.
// RQ17: data changes on leading edge, sampled on trailing edge, one bit each.
// RQ18: two-character queue; third character sets overrun, keeps data, blocks reception.
// RQ19: pin events synchronised into system clock before flags update.
// RQ20: data read pops oldest; receive-done clears when queue empty.
`include "sssp_regs.vh"
module sssp_sync_slave #(
	parameter ADDR_W = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire shift_clock_pin_i,
	output wire shift_clock_pin_o,
	output wire shift_clock_pin_oe,
	input wire serial_data_pin_i,
	output reg serial_data_pin_o,
	output wire serial_data_pin_oe,
	output wire core_wake,
	output wire core_irq
);
	reg [7:0] transmit_status_control_r;
	reg [7:0] receive_status_control_r;
	reg [7:0] irqen_r;
	reg [7:0] baud_r;
	reg [7:0] divlo_r;
	reg [7:0] divhi_r;
	reg [7:0] core_r;
	reg [8:0] hold_r;
	reg hold_full_r;
	reg [8:0] tsh_r;
	reg tsh_busy_r;
	reg [3:0] tcnt_r;
	reg [8:0] rsh_r;
	reg [3:0] rcnt_r;
	reg [8:0] q0_r;
	reg [8:0] q1_r;
	reg [1:0] qcnt_r;
	reg overrun_flag_r;
	reg [2:0] ck_r;
	reg [1:0] dt_r;
	reg aw_got_r;
	reg w_got_r;
	reg [ADDR_W-1:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;

	wire port_en = receive_status_control_r[`SSSP_RC_PEN];
	wire slave_mode = transmit_status_control_r[`SSSP_TX_SYNC] & port_en & ~transmit_status_control_r[`SSSP_TX_CLOCK_SOURCE_SELECT]; // RQ1
	wire rx_mode = receive_status_control_r[`SSSP_RC_SINGLE_RECEIVE_ENABLE] | receive_status_control_r[`SSSP_RC_CONTINUOUS_RECEIVE_ENABLE]; // RQ2
	wire continuous_receive_enable = receive_status_control_r[`SSSP_RC_CONTINUOUS_RECEIVE_ENABLE];
	wire tx_active = slave_mode & ~rx_mode & transmit_status_control_r[`SSSP_TX_EN]; // RQ7
	// single receive alone never arms reception in slave mode
	wire rx_active = slave_mode & continuous_receive_enable; // RQ8
	// core control register stands in for sleep and enables
	wire sleeping = core_r[`SSSP_CORE_SLEEP];
	// other modes are clockless during sleep; nothing of them modelled here
	wire run_ok = slave_mode; // RQ14
	wire [3:0] nbits_t = transmit_status_control_r[`SSSP_TX_NINE] ? `SSSP_CHAR9_BITS : `SSSP_CHAR_BITS;
	wire [3:0] nbits_r = receive_status_control_r[`SSSP_RC_NINE] ? `SSSP_CHAR9_BITS : `SSSP_CHAR_BITS;

	// pin synchronisers; first stage read only by second
	always @(posedge aclk) begin
		if (!aresetn) begin
			ck_r <= 3'h0;
			dt_r <= 2'h0;
		end else begin
			ck_r <= {ck_r[1:0], shift_clock_pin_i}; // RQ19
			dt_r <= {dt_r[0], serial_data_pin_i};
		end
	end
	// leading edge is the rise, trailing edge the fall
	wire ck_lead = ck_r[1] & ~ck_r[2]; // RQ17
	wire ck_trail = ~ck_r[1] & ck_r[2]; // RQ17

	// only a master configuration may drive the clock pin
	assign shift_clock_pin_o = 1'b0;
	assign shift_clock_pin_oe = ~slave_mode & port_en & transmit_status_control_r[`SSSP_TX_CLOCK_SOURCE_SELECT]; // RQ16
	assign serial_data_pin_oe = tx_active;

	wire aw_take = s_axi_awvalid & ~aw_got_r;
	wire w_take = s_axi_wvalid & ~w_got_r;
	assign s_axi_awready = ~aw_got_r;
	assign s_axi_wready = ~w_got_r;
	wire wr_go = aw_got_r & w_got_r & ~s_axi_bvalid;
	wire wr_hit = wr_go & wstrb_r[0];
	wire [ADDR_W-1:0] wa = awaddr_r;
	wire txhold_wr = wr_hit & (wa == `SSSP_TXHOLD_OFF);
	assign s_axi_arready = ~s_axi_rvalid;
	wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
	// a data read pops as the address is accepted
	wire rxdata_rd = rd_go & (s_axi_araddr == `SSSP_RXDATA_OFF);
	wire receive_status_control_wr = wr_hit & (wa == `SSSP_RECEIVE_STATUS_CONTROL_OFF);
	wire continuous_receive_enable_clr = receive_status_control_wr & continuous_receive_enable & ~wdata_r[`SSSP_RC_CONTINUOUS_RECEIVE_ENABLE];
	wire pen_clr = receive_status_control_wr & port_en & ~wdata_r[`SSSP_RC_PEN];
	// mapped aligned words answer okay, the rest slave error
	wire wr_addr_ok = (wa <= `SSSP_CORE_OFF) && (wa[1:0] == 2'h0);
	wire rd_addr_ok = (s_axi_araddr <= `SSSP_CORE_OFF) && (s_axi_araddr[1:0] == 2'h0);

	// transmit path
	wire tx_done = tx_active & tsh_busy_r & ck_trail & (tcnt_r == nbits_t - 4'h1);
	wire tx_free = ~tsh_busy_r | tx_done;
	// ready flag mirrors an empty holding register
	wire transmit_ready_flag = ~hold_full_r; // RQ3 RQ4
	always @(posedge aclk) begin
		if (!aresetn || pen_clr || !port_en) begin
			hold_r <= 9'h000;
			hold_full_r <= 1'b0;
			tsh_r <= 9'h000;
			tsh_busy_r <= 1'b0;
			tcnt_r <= 4'h0;
			serial_data_pin_o <= 1'b0;
		end else begin
			// holding write refused while a word still waits
			if (txhold_wr && !hold_full_r) begin
				hold_r <= {transmit_status_control_r[`SSSP_TX_NINTH], wdata_r[7:0]}; // RQ6 RQ7
				hold_full_r <= 1'b1;
			end
			if (tx_active && hold_full_r && tx_free) begin
				// pending word enters shifter when it frees up
				tsh_r <= hold_r; // RQ3 RQ4
				tsh_busy_r <= 1'b1;
				tcnt_r <= 4'h0;
				hold_full_r <= 1'b0;
			end else if (tx_done) begin
				tsh_busy_r <= 1'b0;
			end
			if (tx_active && tsh_busy_r && run_ok) begin
				if (ck_lead) begin
					serial_data_pin_o <= tsh_r[0]; // RQ15 RQ17
				end
				if (ck_trail && !tx_done) begin
					tsh_r <= {1'b0, tsh_r[8:1]};
					tcnt_r <= tcnt_r + 4'h1;
				end
			end else if (tx_active && hold_full_r && tx_free) begin
				serial_data_pin_o <= hold_r[0];
			end
		end
	end

	// receive path
	// shifter halts while an overrun stands
	wire rx_done = rx_active & ~overrun_flag_r & ck_trail & (rcnt_r == nbits_r - 4'h1);
	// last bit is taken straight from the pin with the done edge
	wire [8:0] rx_word = receive_status_control_r[`SSSP_RC_NINE] ? {dt_r[1], rsh_r[8:1]} : {1'b0, dt_r[1], rsh_r[8:2]};
	wire pop = rxdata_rd & (qcnt_r != 2'h0);
	wire overrun_flag_set = rx_done & (qcnt_r == 2'h2) & ~pop;
	// a third word lands only when a read frees a slot at once
	wire push = rx_done & ((qcnt_r != 2'h2) | pop);
	always @(posedge aclk) begin
		if (!aresetn || pen_clr || !port_en) begin
			rsh_r <= 9'h000;
			rcnt_r <= 4'h0;
			q0_r <= 9'h000;
			q1_r <= 9'h000;
			qcnt_r <= 2'h0;
			overrun_flag_r <= 1'b0;
		end else begin
			if (!rx_active) begin
				rcnt_r <= 4'h0;
			end else if (ck_trail && !overrun_flag_r && run_ok) begin
				rsh_r <= {dt_r[1], rsh_r[8:1]}; // RQ15 RQ17 RQ9
				rcnt_r <= rx_done ? 4'h0 : rcnt_r + 4'h1;
			end
			// a completing third word beats a clear in the same cycle
			if (overrun_flag_set) begin
				overrun_flag_r <= 1'b1; // RQ18
			end else if (continuous_receive_enable_clr) begin
				overrun_flag_r <= 1'b0; // RQ13
			end
			// pop and push in one cycle are both honoured
			case ({push, pop})
				2'b10: begin
					if (qcnt_r == 2'h0) begin
						q0_r <= rx_word;
					end else begin
						q1_r <= rx_word;
					end
					qcnt_r <= qcnt_r + 2'h1; // RQ11
				end
				2'b01: begin
					q0_r <= q1_r; // RQ20
					qcnt_r <= qcnt_r - 2'h1;
				end
				2'b11: begin
					if (qcnt_r == 2'h1) begin
						q0_r <= rx_word;
					end else begin
						q0_r <= q1_r;
						q1_r <= rx_word;
					end
				end
				default: begin
					qcnt_r <= qcnt_r;
				end
			endcase
		end
	end
	wire receive_done_flag = (qcnt_r != 2'h0); // RQ11 RQ20

	wire peripheral_irq_en = core_r[`SSSP_CORE_PERIPHERAL_IRQ_EN];
	wire tx_req = transmit_ready_flag & irqen_r[`SSSP_IRQ_TX] & tx_active;
	wire rx_req = receive_done_flag & irqen_r[`SSSP_IRQ_RX]; // RQ11
	wire any_req = tx_req | rx_req;
	// wake and request leave the block from flip-flops
	reg wake_r;
	reg irq_r;
	always @(posedge aclk) begin
		if (!aresetn) begin
			wake_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			wake_r <= sleeping & peripheral_irq_en & any_req; // RQ5 RQ10
			irq_r <= core_r[`SSSP_CORE_GIE] & peripheral_irq_en & any_req; // RQ5 RQ10
		end
	end
	assign core_wake = wake_r;
	assign core_irq = irq_r;

	// register write side
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= {ADDR_W{1'b0}};
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			transmit_status_control_r <= `SSSP_TRANSMIT_STATUS_CONTROL_RST;
			receive_status_control_r <= `SSSP_ZERO_RST;
			irqen_r <= `SSSP_ZERO_RST;
			baud_r <= `SSSP_ZERO_RST;
			divlo_r <= `SSSP_ZERO_RST;
			divhi_r <= `SSSP_ZERO_RST;
			core_r <= `SSSP_ZERO_RST;
		end else begin
			if (aw_take) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_addr_ok ? `SSSP_RESP_OKAY : `SSSP_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_hit) begin
				case (wa)
					`SSSP_TRANSMIT_STATUS_CONTROL_OFF: transmit_status_control_r <= {wdata_r[7:2], 1'b0, wdata_r[0]};
					`SSSP_RECEIVE_STATUS_CONTROL_OFF: begin
						// disabling the port resets the whole port
						if (!wdata_r[`SSSP_RC_PEN]) begin
							receive_status_control_r <= `SSSP_ZERO_RST; // RQ13
						end else begin
							receive_status_control_r <= {wdata_r[7:2], 2'h0};
						end
					end
					`SSSP_IRQEN_OFF: irqen_r <= wdata_r[7:0];
					`SSSP_BAUD_OFF: baud_r <= wdata_r[7:0];
					`SSSP_DIVLO_OFF: divlo_r <= wdata_r[7:0];
					`SSSP_DIVHI_OFF: divhi_r <= wdata_r[7:0];
					`SSSP_CORE_OFF: core_r <= wdata_r[7:0];
					default: core_r <= core_r;
				endcase
			end
		end
	end

	// register read side
	// shifter-empty and flag bits are live views
	wire [7:0] transmit_status_control_v = {transmit_status_control_r[7:2], ~tsh_busy_r, transmit_status_control_r[0]};
	wire [7:0] receive_status_control_v = {receive_status_control_r[7:2], overrun_flag_r, q0_r[8]}; // RQ12
	wire [7:0] irqflg_v = {2'h0, receive_done_flag, transmit_ready_flag, 4'h0};
	reg [31:0] rd_v;
	always @* begin
		rd_v = 32'h00000000;
		case (s_axi_araddr)
			`SSSP_TRANSMIT_STATUS_CONTROL_OFF: rd_v = {24'h000000, transmit_status_control_v};
			`SSSP_RECEIVE_STATUS_CONTROL_OFF: rd_v = {24'h000000, receive_status_control_v};
			`SSSP_RXDATA_OFF: rd_v = {24'h000000, q0_r[7:0]}; // RQ12
			`SSSP_IRQEN_OFF: rd_v = {24'h000000, irqen_r};
			`SSSP_IRQFLG_OFF: rd_v = {24'h000000, irqflg_v};
			`SSSP_BAUD_OFF: rd_v = {24'h000000, baud_r};
			`SSSP_DIVLO_OFF: rd_v = {24'h000000, divlo_r};
			`SSSP_DIVHI_OFF: rd_v = {24'h000000, divhi_r};
			`SSSP_CORE_OFF: rd_v = {24'h000000, core_r};
			default: rd_v = 32'h00000000;
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_v;
			s_axi_rresp <= rd_addr_ok ? `SSSP_RESP_OKAY : `SSSP_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ===== sssp_sync_slave_properties.sv
`timescale 1ns/1ps
module sssp_sync_slave_props #(
	parameter ADDR_W = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire shift_clock_pin_i,
	input wire shift_clock_pin_o,
	input wire shift_clock_pin_oe,
	input wire serial_data_pin_o,
	input wire serial_data_pin_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	clk_drive_off_a: assert property (serial_data_pin_oe |-> !shift_clock_pin_oe && !shift_clock_pin_o) else $error("shift clock driven");
	rd_answer_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read not answered");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer dropped");
	wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
	bad_rd_a: assert property (rd_taken and s_axi_araddr == 8'h28 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read accepted");
	bad_wr_a: assert property (wr_taken and s_axi_awaddr == 8'h28 |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h2)
		else $error("unmapped write accepted");
	good_rd_a: assert property (rd_taken and s_axi_araddr < 8'h28 && s_axi_araddr[1:0] == 2'h0
		|=> s_axi_rresp == 2'h0) else $error("mapped read refused");
	data_hold_a: assert property ($fell(shift_clock_pin_i) && serial_data_pin_oe |-> $stable(serial_data_pin_o)[*3])
		else $error("data moved at trailing edge");
endmodule
bind sssp_sync_slave sssp_sync_slave_props #(.ADDR_W(ADDR_W)) props_i (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.shift_clock_pin_i(shift_clock_pin_i), .shift_clock_pin_o(shift_clock_pin_o), .shift_clock_pin_oe(shift_clock_pin_oe),
	.serial_data_pin_o(serial_data_pin_o), .serial_data_pin_oe(serial_data_pin_oe));

// ===== sssp_link_master.sv
`timescale 1ns/1ps
module sssp_link_master (
	output logic sck,
	output logic m_d,
	input wire line
);
	initial begin
		sck = 0;
		m_d = 1;
	end
	// clock idles low between frames
	task shift(input logic [8:0] tx, input int n, output logic [8:0] rx);
		rx = 0;
		#3;
		for (int i = 0; i < n; i++) begin
			sck = 1;
			m_d = tx[i];
			#40;
			sck = 0;
			rx[i] = line;
			#40;
		end
		// released line shows the inverse of its last value
		m_d = ~m_d;
	endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, v;
	logic [8:0] rx;
	logic [1:0] br, rr;
	wire [31:0] s_axi_rdata;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire ck, md, so, soe, cko, ckoe, wake, irq;
	int errors = 0, checks_done = 0;
	wire dl = soe ? so : md;
	sssp_sync_slave dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
		.shift_clock_pin_i(ck), .shift_clock_pin_o(cko), .shift_clock_pin_oe(ckoe), .serial_data_pin_i(dl),
		.serial_data_pin_o(so), .serial_data_pin_oe(soe), .core_wake(wake), .core_irq(irq));
	sssp_link_master lm (.sck(ck), .m_d(md), .line(dl));
	initial forever #5 aclk = ~aclk;
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic aw, w;
		aw = 1;
		w = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 0;
				s_axi_awvalid <= 0;
			end
			if (w && s_axi_wready) begin
				w = 0;
				s_axi_wvalid <= 0;
			end
		end while (!s_axi_bvalid);
		br = s_axi_bresp;
	endtask
	task rc(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		rr = s_axi_rresp;
		chk(n, v & {24'hFFFFFF, m}, {24'h0, e});
	endtask
	task wait3;
		repeat (3) @(posedge aclk);
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		give_verdict;
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rc("transmit_status_control rst", 8'h00, 8'hFF, 8'h02);
		rc("flags rst", 8'h14, 8'hFF, 8'h10);
		rc("receive_status_control rst", 8'h04, 8'hFF, 8'h00);
		rc("unmapped", 8'h28, 8'hFF, 8'h00);
		chk("unmapped rd resp", rr, 2'h2);
		wr(8'h28, 8'h55);
		chk("unmapped wr resp", br, 2'h2);
		wr(8'h04, 8'h80);
		wr(8'h00, 8'h71);
		wr(8'h10, 8'h10);
		wr(8'h24, 8'hC1);
		wr(8'h08, 8'hA5);
		wr(8'h08, 8'h3C);
		rc("tx ready held", 8'h14, 8'h10, 8'h00);
		chk("pins tx", {ckoe, soe, wake}, 3'b010);
		lm.shift(9'h0, 9, rx);
		chk("tx char 1", rx, 9'h1A5);
		wait3;
		rc("tx ready set", 8'h14, 8'h10, 8'h10);
		chk("tx wake", {wake, irq}, 2'b11);
		lm.shift(9'h0, 9, rx);
		chk("tx char 2", rx, 9'h13C);
		$display("test transmit done");
		wr(8'h00, 8'h10);
		wr(8'h04, 8'hF0);
		wr(8'h10, 8'h20);
		@(posedge aclk);
		chk("rx masked", {wake, soe, ckoe}, 3'b000);
		lm.shift(9'h155, 9, rx);
		wait3;
		rc("rx done", 8'h14, 8'h20, 8'h20);
		chk("rx wake", {wake, irq}, 2'b11);
		lm.shift(9'h0AA, 9, rx);
		lm.shift(9'h1FF, 9, rx);
		wait3;
		rc("overrun", 8'h04, 8'h03, 8'h03);
		rc("rx data 1", 8'h0C, 8'hFF, 8'h55);
		rc("ninth 2", 8'h04, 8'h01, 8'h00);
		rc("rx data 2", 8'h0C, 8'hFF, 8'hAA);
		rc("rx empty", 8'h14, 8'h20, 8'h00);
		wr(8'h04, 8'hC0);
		rc("overrun clr", 8'h04, 8'h02, 8'h00);
		$display("test receive done");
		wr(8'h04, 8'h90);
		lm.shift(9'h05A, 8, rx);
		wait3;
		rc("rx 8 bit", 8'h0C, 8'hFF, 8'h5A);
		lm.shift(9'h0C3, 8, rx);
		wait3;
		rc("rx pending", 8'h14, 8'h20, 8'h20);
		wr(8'h04, 8'h00);
		rc("port off flags", 8'h14, 8'h20, 8'h00);
		rc("port off ctl", 8'h04, 8'hFF, 8'h00);
		$display("test eight bit done");
		give_verdict;
	end
endmodule
